// ### rtl/cpcr_regs.sv
`timescale 1ns/1ns
module cpcr_regs
  import cpcr_pkg::*;
(
  input  wire logic          mclk_i,                  // Master clock, 125 MHz
  input  wire logic          resetn_i,                // Async reset, active low
  input  wire logic [AW-1:0] avs_address_i,           // Byte address
  input  wire logic          avs_read_i,              // Read request
  input  wire logic          avs_write_i,             // Write request
  input  wire logic [DW-1:0] avs_writedata_i,         // Write data
  input  wire logic [3:0]    avs_byteenable_i,        // Byte lanes
  output logic [DW-1:0]      avs_readdata_o,          // Read data
  output logic [1:0]         avs_response_o,          // 00 okay, 11 decode error
  output logic               avs_waitrequest_o,       // Stall
  output logic               bias_detect_enable_o,    // Bias detect enable
  output logic               bias_supply_enable_o,    // Bias supply enable
  output logic [2:0]         bias_level_select_o,     // Raw level code
  output logic [11:0]        microphone_bias_mv_o,    // Nominal level, mV
  output logic               dmic_oversample_select_o,// Oversample setting
  output logic               left_input_amp_enable_o, // Left input amp
  output logic               right_input_amp_enable_o,// Right input amp
  output logic               left_headphone_enable_o, // Left headphone
  output logic               right_headphone_enable_o,// Right headphone
  output logic               left_line_out_enable_o,  // Left line out
  output logic               right_line_out_enable_o, // Right line out
  output logic               left_converter_enable_o, // Left converter
  output logic               right_converter_enable_o,// Right converter
  output logic               left_dmic_proc_enable_o, // Left dmic processing
  output logic               right_dmic_proc_enable_o,// Right dmic processing
  output logic               system_clock_en_o,       // System clock enable pulse
  output logic [3:0]         system_clock_ratio_select_o,   // Ratio code
  output logic [10:0]        system_clock_ratio_o,          // Ratio value, 0 if reserved
  output logic               system_clock_ratio_valid_o,    // Ratio code defined
  output logic [2:0]         sample_rate_code_o,      // Sample rate code
  output logic               sample_rate_valid_o,     // Rate code defined
  output logic               zero_cross_timeout_clock_o // Timeout tick pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [DW-1:0] wd,
                                           input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0]  = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  function automatic logic reg_hit(input logic [5:0] idx);
    case (idx)
      IDX_MIC_BIAS_CONTROL_A, IDX_MIC_BIAS_CONTROL_B, IDX_DMIC_OVERSAMPLE_CFG,
      IDX_INPUT_AMP_POWER, IDX_HEADPHONE_POWER, IDX_LINE_OUTPUT_POWER,
      IDX_CONVERTER_POWER, IDX_CLOCK_RATES_A, IDX_CLOCK_RATES_B,
      IDX_CLOCK_RATES_C: return 1'b1;
      default:           return 1'b0;
    endcase
  endfunction

  // Undocumented bits are not stored and read as zero
  function automatic logic [15:0] reg_image(input logic [5:0] idx, input cpcr_state_t s);
    logic [15:0] r;
    r = 16'h0000;
    case (idx)
      IDX_MIC_BIAS_CONTROL_A: begin
        r[POS_BIAS_DETECT] = s.bias_det;
        r[POS_BIAS_SUPPLY] = s.bias_sup;
      end
      IDX_MIC_BIAS_CONTROL_B:  r[POS_BIAS_LEVEL +: 3] = s.bias_sel;
      IDX_DMIC_OVERSAMPLE_CFG: r[POS_DMIC_OSR] = s.dmic_osr;
      IDX_INPUT_AMP_POWER:     r[POS_RIGHT +: 2] = s.inamp;
      IDX_HEADPHONE_POWER:     r[POS_RIGHT +: 2] = s.hp;
      IDX_LINE_OUTPUT_POWER:   r[POS_RIGHT +: 2] = s.line;
      IDX_CONVERTER_POWER:     r[POS_RIGHT_DMIC +: 4] = s.conv;
      IDX_CLOCK_RATES_A: begin
        r[POS_ZERO_CROSS_TIMEOUT_CLOCK_DIV16] = s.div16;
        r[POS_ZERO_CROSS_TIMEOUT_CLOCK_X4]    = s.x4;
        r[POS_MCLK_HALVE]  = s.mclk_halve;
      end
      IDX_CLOCK_RATES_B: begin
        r[POS_SYSTEM_CLOCK_RATIO +: 4] = s.ratio;
        r[POS_SAMPLE_RATE +: 3]  = s.rate;
      end
      IDX_CLOCK_RATES_C:       r[POS_ZERO_CROSS_TIMEOUT_CLOCK_ENABLE] = s.toen;
      default:                 r = 16'h0000;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cpcr_state_t st_r;
  cpcr_state_t st_nxt;
  logic [5:0]  idx;
  logic        req;
  logic        wr_take;
  logic [15:0] merged;
  cpcr_zero_cross_timeout_clock_if tc ();

  assign idx     = avs_address_i[7:2];
  assign req     = avs_read_i | avs_write_i;
  // One wait state: the answer is prepared in the first cycle
  assign avs_waitrequest_o = req & ~st_r.ack;
  assign wr_take = avs_write_i & st_r.ack;
  assign merged  = be_merge(reg_image(idx, st_r), avs_writedata_i, avs_byteenable_i);

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = req & ~st_r.ack;
    st_nxt.sys_phase = ~st_r.sys_phase;
    if (req && !st_r.ack) begin
      st_nxt.rdata = (avs_read_i && reg_hit(idx)) ? reg_image(idx, st_r) : 16'h0000;
      st_nxt.resp  = reg_hit(idx) ? RESP_OKAY : RESP_DECERR;
    end
    if (wr_take) begin
      case (idx)
        IDX_MIC_BIAS_CONTROL_A: begin
          st_nxt.bias_det = merged[POS_BIAS_DETECT];
          st_nxt.bias_sup = merged[POS_BIAS_SUPPLY];
        end
        IDX_MIC_BIAS_CONTROL_B:  st_nxt.bias_sel = merged[POS_BIAS_LEVEL +: 3];
        IDX_DMIC_OVERSAMPLE_CFG: st_nxt.dmic_osr = merged[POS_DMIC_OSR];
        IDX_INPUT_AMP_POWER:     st_nxt.inamp = merged[POS_RIGHT +: 2];
        IDX_HEADPHONE_POWER:     st_nxt.hp = merged[POS_RIGHT +: 2];
        IDX_LINE_OUTPUT_POWER:   st_nxt.line = merged[POS_RIGHT +: 2];
        IDX_CONVERTER_POWER:     st_nxt.conv = merged[POS_RIGHT_DMIC +: 4];
        IDX_CLOCK_RATES_A: begin
          st_nxt.div16      = merged[POS_ZERO_CROSS_TIMEOUT_CLOCK_DIV16];
          st_nxt.x4         = merged[POS_ZERO_CROSS_TIMEOUT_CLOCK_X4];
          st_nxt.mclk_halve = merged[POS_MCLK_HALVE];
        end
        IDX_CLOCK_RATES_B: begin
          // Reserved codes are stored as written and flagged invalid
          st_nxt.ratio = merged[POS_SYSTEM_CLOCK_RATIO +: 4];
          st_nxt.rate  = merged[POS_SAMPLE_RATE +: 3];
        end
        IDX_CLOCK_RATES_C:       st_nxt.toen = merged[POS_ZERO_CROSS_TIMEOUT_CLOCK_ENABLE];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) st_r <= ST_RESET;
    else           st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata_o = {16'h0000, st_r.rdata};
  assign avs_response_o = st_r.resp;

  assign bias_detect_enable_o     = st_r.bias_det;
  assign bias_supply_enable_o     = st_r.bias_sup;
  assign bias_level_select_o      = st_r.bias_sel;
  always_comb begin
    case (st_r.bias_sel)
      3'h0:    microphone_bias_mv_o = BIAS_MV_0;
      3'h1:    microphone_bias_mv_o = BIAS_MV_1;
      3'h2:    microphone_bias_mv_o = BIAS_MV_2;
      3'h3:    microphone_bias_mv_o = BIAS_MV_3;
      default: microphone_bias_mv_o = BIAS_MV_TOP;
    endcase
  end
  assign dmic_oversample_select_o = st_r.dmic_osr;
  assign left_input_amp_enable_o  = st_r.inamp[POS_LEFT];
  assign right_input_amp_enable_o = st_r.inamp[POS_RIGHT];
  assign left_headphone_enable_o  = st_r.hp[POS_LEFT];
  assign right_headphone_enable_o = st_r.hp[POS_RIGHT];
  assign left_line_out_enable_o   = st_r.line[POS_LEFT];
  assign right_line_out_enable_o  = st_r.line[POS_RIGHT];
  assign left_converter_enable_o  = st_r.conv[POS_LEFT_CONV];
  assign right_converter_enable_o = st_r.conv[POS_RIGHT_CONV];
  assign left_dmic_proc_enable_o  = st_r.conv[POS_LEFT_DMIC];
  assign right_dmic_proc_enable_o = st_r.conv[POS_RIGHT_DMIC];

  // Halving is an every-other-cycle enable; no derived clock is built
  assign system_clock_en_o     = ~st_r.mclk_halve | st_r.sys_phase;
  assign system_clock_ratio_select_o = st_r.ratio;
  assign system_clock_ratio_o        = system_clock_ratio_value(st_r.ratio);
  assign system_clock_ratio_valid_o  = (system_clock_ratio_value(st_r.ratio) != 11'h000);
  assign sample_rate_code_o    = st_r.rate;
  assign sample_rate_valid_o   = (st_r.rate <= 3'h5);

  // ----------------------------------------------------------------
  // Timeout tick generator
  // ----------------------------------------------------------------
  assign tc.sys_tick = system_clock_en_o;
  assign tc.enable   = st_r.toen;
  assign tc.div16    = st_r.div16;
  assign tc.x4       = st_r.x4;
  assign zero_cross_timeout_clock_o = tc.tick;

  cpcr_zero_cross_timeout_clock_gen u_zero_cross_timeout_clock (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .tc       (tc.gen)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_BUS_ANSWER: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    req |-> ##[0:1] !avs_waitrequest_o)
    else $error("bus request not answered within one wait state");
  AST_BIAS_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_MIC_BIAS_CONTROL_A && avs_byteenable_i[0]
    |=> bias_detect_enable_o == $past(avs_writedata_i[1])
        && bias_supply_enable_o == $past(avs_writedata_i[0]))
    else $error("bias enables not updated by write");
  AST_BIAS_LEVEL: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_MIC_BIAS_CONTROL_B && avs_byteenable_i[0] && avs_writedata_i[2]
    |=> microphone_bias_mv_o == BIAS_MV_TOP)
    else $error("upper bias codes not at top level");
  AST_INAMP_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_INPUT_AMP_POWER && avs_byteenable_i[0]
    |=> {left_input_amp_enable_o, right_input_amp_enable_o} == $past(avs_writedata_i[1:0]))
    else $error("input amp enables wrong");
  AST_HP_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_HEADPHONE_POWER && avs_byteenable_i[0]
    |=> {left_headphone_enable_o, right_headphone_enable_o} == $past(avs_writedata_i[1:0]))
    else $error("headphone enables wrong");
  AST_LINE_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_LINE_OUTPUT_POWER && avs_byteenable_i[0]
    |=> {left_line_out_enable_o, right_line_out_enable_o} == $past(avs_writedata_i[1:0]))
    else $error("line out enables wrong");
  AST_CONV_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_CONVERTER_POWER && avs_byteenable_i[0]
    |=> {left_converter_enable_o, right_converter_enable_o} == $past(avs_writedata_i[3:2]))
    else $error("converter enables wrong");
  AST_DMIC_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_CONVERTER_POWER && avs_byteenable_i[0]
    |=> {left_dmic_proc_enable_o, right_dmic_proc_enable_o} == $past(avs_writedata_i[1:0]))
    else $error("dmic processing enables wrong");
  AST_SYSTEM_CLOCK_HALF: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    st_r.mclk_halve && $past(st_r.mclk_halve) |-> system_clock_en_o != $past(system_clock_en_o))
    else $error("halved system clock enable not alternating");
  AST_SYSTEM_CLOCK_FULL: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !st_r.mclk_halve |-> system_clock_en_o)
    else $error("system clock enable missing");
  AST_RATIO_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_CLOCK_RATES_B && avs_byteenable_i[1] && avs_writedata_i[13:10] == 4'h9
    |=> system_clock_ratio_o == 11'h600)
    else $error("ratio code 9 not 1536");
  AST_RATE_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_CLOCK_RATES_B && avs_byteenable_i[0]
    |=> sample_rate_code_o == $past(avs_writedata_i[2:0]))
    else $error("sample rate code not updated");
  AST_RATIO_RSVD: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    system_clock_ratio_select_o >= 4'hA |-> !system_clock_ratio_valid_o && system_clock_ratio_o == 11'h000)
    else $error("reserved ratio code reported valid");
  AST_ZERO_CROSS_TIMEOUT_CLOCK_OFF: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !st_r.toen [*2] |-> !zero_cross_timeout_clock_o)
    else $error("timeout tick without enable");

  COV_WRITE_RATES: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_take && idx == IDX_CLOCK_RATES_B);
  COV_READ_DONE: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    avs_read_i && !avs_waitrequest_o);
  COV_DECERR: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    req && !avs_waitrequest_o && avs_response_o == RESP_DECERR);

endmodule // cpcr_regs

// ### rtl/cpcr_pkg.sv
package cpcr_pkg;

  // ----------------------------------------------------------------
  // Bus and register indices (byte address = 4 x index)
  // ----------------------------------------------------------------
  localparam int         AW = 8;
  localparam int         DW = 32;
  localparam logic [5:0] IDX_MIC_BIAS_CONTROL_A  = 6'h06;
  localparam logic [5:0] IDX_MIC_BIAS_CONTROL_B  = 6'h07;
  localparam logic [5:0] IDX_DMIC_OVERSAMPLE_CFG = 6'h0A;
  localparam logic [5:0] IDX_INPUT_AMP_POWER     = 6'h0C;
  localparam logic [5:0] IDX_HEADPHONE_POWER     = 6'h0E;
  localparam logic [5:0] IDX_LINE_OUTPUT_POWER   = 6'h0F;
  localparam logic [5:0] IDX_CONVERTER_POWER     = 6'h12;
  localparam logic [5:0] IDX_CLOCK_RATES_A       = 6'h14;
  localparam logic [5:0] IDX_CLOCK_RATES_B       = 6'h15;
  localparam logic [5:0] IDX_CLOCK_RATES_C       = 6'h16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_BIAS_DETECT   = 1;
  localparam int POS_BIAS_SUPPLY   = 0;
  localparam int POS_BIAS_LEVEL    = 0;
  localparam int POS_DMIC_OSR      = 0;
  localparam int POS_LEFT          = 1;
  localparam int POS_RIGHT         = 0;
  localparam int POS_LEFT_CONV     = 3;
  localparam int POS_RIGHT_CONV    = 2;
  localparam int POS_LEFT_DMIC     = 1;
  localparam int POS_RIGHT_DMIC    = 0;
  localparam int POS_ZERO_CROSS_TIMEOUT_CLOCK_DIV16   = 14;
  localparam int POS_ZERO_CROSS_TIMEOUT_CLOCK_X4      = 13;
  localparam int POS_MCLK_HALVE    = 0;
  localparam int POS_SYSTEM_CLOCK_RATIO  = 10;
  localparam int POS_SAMPLE_RATE   = 0;
  localparam int POS_ZERO_CROSS_TIMEOUT_CLOCK_ENABLE  = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic       RST_DMIC_OSR     = 1'b1;
  localparam logic [3:0] RST_SYSTEM_CLOCK_RATIO = 4'h3;
  localparam logic [2:0] RST_SAMPLE_RATE  = 3'h5;
  // Base divisor of the timeout tick in system clock ticks
  localparam logic [12:0] ZERO_CROSS_TIMEOUT_CLOCK_BASE_DIV  = 13'h0100;

  // Nominal bias level in mV at the reference analogue supply
  localparam logic [11:0] BIAS_MV_0   = 12'h640;
  localparam logic [11:0] BIAS_MV_1   = 12'h7D0;
  localparam logic [11:0] BIAS_MV_2   = 12'h834;
  localparam logic [11:0] BIAS_MV_3   = 12'h960;
  localparam logic [11:0] BIAS_MV_TOP = 12'hA8C;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
    logic [1:0]  resp;
    logic        sys_phase;
    logic        bias_det;
    logic        bias_sup;
    logic [2:0]  bias_sel;
    logic        dmic_osr;
    logic [1:0]  inamp;
    logic [1:0]  hp;
    logic [1:0]  line;
    logic [3:0]  conv;
    logic        div16;
    logic        x4;
    logic        mclk_halve;
    logic [3:0]  ratio;
    logic [2:0]  rate;
    logic        toen;
  } cpcr_state_t;

  localparam cpcr_state_t ST_RESET = '{ack: 1'b0, rdata: 16'h0000, resp: RESP_OKAY,
    sys_phase: 1'b0, bias_det: 1'b0, bias_sup: 1'b0, bias_sel: 3'h0,
    dmic_osr: RST_DMIC_OSR, inamp: 2'h0, hp: 2'h0, line: 2'h0, conv: 4'h0,
    div16: 1'b0, x4: 1'b0, mclk_halve: 1'b0, ratio: RST_SYSTEM_CLOCK_RATIO,
    rate: RST_SAMPLE_RATE, toen: 1'b0};

  typedef struct packed {
    logic [12:0] cnt;
    logic        tick;
  } cpcr_zero_cross_timeout_clock_state_t;

  function automatic logic [10:0] system_clock_ratio_value(input logic [3:0] code);
    case (code)
      4'h0:    return 11'h040;
      4'h1:    return 11'h080;
      4'h2:    return 11'h0C0;
      4'h3:    return 11'h100;
      4'h4:    return 11'h180;
      4'h5:    return 11'h200;
      4'h6:    return 11'h300;
      4'h7:    return 11'h400;
      4'h8:    return 11'h580;
      4'h9:    return 11'h600;
      default: return 11'h000;
    endcase
  endfunction

  function automatic logic [12:0] zero_cross_timeout_clock_period(input logic div16, input logic x4);
    logic [12:0] p;
    p = ZERO_CROSS_TIMEOUT_CLOCK_BASE_DIV;
    if (div16) p = p << 4;
    if (x4)    p = p >> 2;
    return p;
  endfunction

endpackage

// ### rtl/cpcr_zero_cross_timeout_clock_if.sv
`timescale 1ns/1ns
interface cpcr_zero_cross_timeout_clock_if;
  logic sys_tick;
  logic enable;
  logic div16;
  logic x4;
  logic tick;
  modport ctrl (output sys_tick, output enable, output div16, output x4, input tick);
  modport gen  (input sys_tick, input enable, input div16, input x4, output tick);
endinterface

// ### rtl/cpcr_zero_cross_timeout_clock_gen.sv
`timescale 1ns/1ns
module cpcr_zero_cross_timeout_clock_gen
  import cpcr_pkg::*;
(
  input  wire logic   mclk_i,   // Core clock
  input  wire logic   resetn_i, // Async reset, active low
  cpcr_zero_cross_timeout_clock_if.gen   tc        // Control and tick
);

  cpcr_zero_cross_timeout_clock_state_t st_r;
  cpcr_zero_cross_timeout_clock_state_t st_nxt;
  logic [12:0]       period;

  assign period = zero_cross_timeout_clock_period(tc.div16, tc.x4);
  assign tc.tick = st_r.tick;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!tc.enable) begin
      st_nxt.cnt = 13'h0000;
    end else if (tc.sys_tick) begin
      // >= keeps a shortened period from running the count away
      if (st_r.cnt >= period - 13'h0001) begin
        st_nxt.cnt  = 13'h0000;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 13'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) st_r <= '0;
    else           st_r <= st_nxt;
  end

  AST_ZERO_CROSS_TIMEOUT_CLOCK_GATED: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !tc.enable |=> !tc.tick)
    else $error("timeout tick while disabled");
  AST_ZERO_CROSS_TIMEOUT_CLOCK_DIV16: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tc.enable && tc.div16 && !tc.x4 && st_r.cnt < 13'h1000 |=> st_r.cnt < 13'h1000)
    else $error("divide by sixteen count out of range");
  AST_ZERO_CROSS_TIMEOUT_CLOCK_X4: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tc.enable && tc.x4 && !tc.div16 && st_r.cnt < 13'h0040 |=> st_r.cnt < 13'h0040)
    else $error("times four count out of range");
  AST_ZERO_CROSS_TIMEOUT_CLOCK_PULSE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tc.tick |=> !tc.tick)
    else $error("timeout tick wider than one cycle");
  COV_ZERO_CROSS_TIMEOUT_CLOCK_TICK: cover property (@(posedge mclk_i) disable iff (!resetn_i) tc.tick);

endmodule // cpcr_zero_cross_timeout_clock_gen

// ### dv/cpcr_regs_test.sv
`timescale 1ns/1ns
module cpcr_regs_test;
  import cpcr_pkg::*;
  // ----------------------------------------------------------------
  // Signals and reference model
  // ----------------------------------------------------------------
  logic            mclk_i = 1'b0, resetn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [AW-1:0]   avs_address_i = '0;
  logic [DW-1:0]   avs_writedata_i = '0, avs_readdata_o;
  logic [3:0]      avs_byteenable_i = 4'h0, system_clock_ratio_select_o;
  logic [1:0]      avs_response_o;
  logic            avs_waitrequest_o, bias_detect_enable_o, bias_supply_enable_o, dmic_oversample_select_o;
  logic            left_input_amp_enable_o, right_input_amp_enable_o, left_headphone_enable_o;
  logic            right_headphone_enable_o, left_line_out_enable_o, right_line_out_enable_o;
  logic            left_converter_enable_o, right_converter_enable_o, left_dmic_proc_enable_o;
  logic            right_dmic_proc_enable_o, system_clock_en_o, system_clock_ratio_valid_o;
  logic            sample_rate_valid_o, zero_cross_timeout_clock_o;
  logic [2:0]      bias_level_select_o, sample_rate_code_o;
  logic [11:0]     microphone_bias_mv_o;
  logic [10:0]     system_clock_ratio_o;
  logic [15:0]     m [64];
  logic [5:0]      ix [10] = '{6'h06, 6'h07, 6'h0A, 6'h0C, 6'h0E, 6'h0F, 6'h12, 6'h14, 6'h15, 6'h16};
  int              rt [10] = '{64, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536};
  int              mvt [8] = '{1600, 2000, 2100, 2400, 2700, 2700, 2700, 2700};
  int              seed = 20, bad_count = 0, num_checks = 0, c, n;
  logic [15:0]     d;
  logic            s;

  always #4 mclk_i = ~mclk_i;
  cpcr_regs DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o),
    .bias_detect_enable_o(bias_detect_enable_o), .bias_supply_enable_o(bias_supply_enable_o),
    .bias_level_select_o(bias_level_select_o), .microphone_bias_mv_o(microphone_bias_mv_o),
    .dmic_oversample_select_o(dmic_oversample_select_o), .left_input_amp_enable_o(left_input_amp_enable_o),
    .right_input_amp_enable_o(right_input_amp_enable_o), .left_headphone_enable_o(left_headphone_enable_o),
    .right_headphone_enable_o(right_headphone_enable_o), .left_line_out_enable_o(left_line_out_enable_o),
    .right_line_out_enable_o(right_line_out_enable_o), .left_converter_enable_o(left_converter_enable_o),
    .right_converter_enable_o(right_converter_enable_o), .left_dmic_proc_enable_o(left_dmic_proc_enable_o),
    .right_dmic_proc_enable_o(right_dmic_proc_enable_o), .system_clock_en_o(system_clock_en_o),
    .system_clock_ratio_select_o(system_clock_ratio_select_o), .system_clock_ratio_o(system_clock_ratio_o),
    .system_clock_ratio_valid_o(system_clock_ratio_valid_o), .sample_rate_code_o(sample_rate_code_o),
    .sample_rate_valid_o(sample_rate_valid_o), .zero_cross_timeout_clock_o(zero_cross_timeout_clock_o)
  );

  function automatic logic [15:0] msk(input logic [5:0] i);
    case (i)
      6'h06, 6'h0C, 6'h0E, 6'h0F: return 16'h0003;
      6'h07:                      return 16'h0007;
      6'h0A, 6'h16:               return 16'h0001;
      6'h12:                      return 16'h000F;
      6'h14:                      return 16'h6001;
      6'h15:                      return 16'h3C07;
      default:                    return 16'h0000;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic outs();
    chk("bias_en", m[6][1:0], {bias_detect_enable_o, bias_supply_enable_o});
    chk("bias_sel", m[7][2:0], bias_level_select_o);
    chk("bias_mv", 16'(mvt[m[7][2:0]]), microphone_bias_mv_o);
    chk("dmic_osr", m[10][0], dmic_oversample_select_o);
    chk("inamp", m[12][1:0], {left_input_amp_enable_o, right_input_amp_enable_o});
    chk("hp", m[14][1:0], {left_headphone_enable_o, right_headphone_enable_o});
    chk("line", m[15][1:0], {left_line_out_enable_o, right_line_out_enable_o});
    chk("conv", m[18][3:0], {left_converter_enable_o, right_converter_enable_o,
                             left_dmic_proc_enable_o, right_dmic_proc_enable_o});
    chk("ratio_sel", m[21][13:10], system_clock_ratio_select_o);
    chk("ratio", m[21][13:10] < 10 ? 16'(rt[m[21][13:10]]) : 16'h0000, system_clock_ratio_o);
    chk("ratio_ok", m[21][13:10] < 10, system_clock_ratio_valid_o);
    chk("rate", m[21][2:0], sample_rate_code_o);
    chk("rate_ok", m[21][2:0] < 6, sample_rate_valid_o);
    if (!m[20][0]) chk("sys_en", 1'b1, system_clock_en_o);
  endtask

  // ----------------------------------------------------------------
  // Bus master: request held until waitrequest is seen low at an edge
  // ----------------------------------------------------------------
  task automatic bus(input bit w, input logic [5:0] i, input logic [15:0] dat, input logic [3:0] be);
    int k;
    logic [15:0] mk;
    k = 0;
    mk = msk(i);
    avs_address_i <= {i, 2'b00};
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= {16'($random(seed)), dat};
    avs_byteenable_i <= be;
    @(negedge mclk_i);
    outs();
    // Waitrequest, read data and response are taken at the accepting rising edge
    do begin
      @(posedge mclk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    if (avs_waitrequest_o !== 1'b0) bad_count++;
    if (!w) chk("readdata", m[i], avs_readdata_o[15:0]);
    if (!w) chk("readhigh", 16'h0000, avs_readdata_o[31:16]);
    chk("response", mk != 0 ? RESP_OKAY : RESP_DECERR, avs_response_o);
    for (int b = 0; b < 2; b++)
      if (w && be[b]) m[i][8*b+:8] = dat[8*b+:8] & mk[8*b+:8];
  endtask

  task automatic rel();
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(negedge mclk_i);
    outs();
    @(posedge mclk_i);
  endtask

  // Cycles from now up to and including the next timeout tick
  task automatic gap(output int g);
    g = 0;
    do begin
      @(negedge mclk_i);
      g++;
    end while (zero_cross_timeout_clock_o !== 1'b1 && g < 20000);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    foreach (m[i]) m[i] = 16'h0000;
    m[10] = 16'h0001;
    m[21] = 16'h0C05;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    foreach (ix[k]) bus(0, ix[k], 16'h0000, 4'hF);
    bus(1, 6'h08, 16'hFFFF, 4'hF);
    bus(0, 6'h20, 16'h0000, 4'hF);
    bus(1, 6'h0A, 16'h0000, 4'h3);
    // Rate codes kept defined and oversampling left normal, as software must
    repeat (3) foreach (ix[k]) begin
      d = 16'($random(seed));
      if (ix[k] == 6'h15) d[2:0] = d[2:0] % 6;
      if (ix[k] == 6'h0A) d[0] = 1'b0;
      bus(1, ix[k], d, 4'($random(seed)));
      bus(0, ix[k], 16'h0000, 4'hF);
    end
    for (int i = 0; i < 16; i++) begin
      bus(1, 6'h15, 16'(i << 10) | 16'(i % 6), 4'h3);
      bus(1, 6'h07, 16'(i), 4'h1);
    end
    bus(1, 6'h16, 16'h0001, 4'h1);
    for (int k = 0; k < 4; k++) begin
      bus(1, 6'h14, 16'(k << 13) | 16'(k == 2), 4'h3);
      rel();
      gap(c);
      gap(c);
      chk("tick_gap", 16'(((256 << (k[1] ? 4 : 0)) >> (k[0] ? 2 : 0)) * (k == 2 ? 2 : 1)), 16'(c));
      s = system_clock_en_o;
      @(negedge mclk_i);
      if (k == 2) chk("sys_alt", 16'(s !== 1'b1), system_clock_en_o);
      @(posedge mclk_i);
    end
    // Short period, so a tick that ignores the enable would show in the window
    bus(1, 6'h14, 16'h2000, 4'h3);
    bus(1, 6'h16, 16'h0000, 4'h1);
    rel();
    n = 0;
    repeat (300) begin
      @(negedge mclk_i);
      if (zero_cross_timeout_clock_o !== 1'b0) n++;
    end
    chk("tick_off", 16'h0000, 16'(n));
    test_done();
  end

  initial begin
    #(60000 * 8);
    bad_count++;
    test_done();
  end
endmodule // cpcr_regs_test
